// ==== pkg/wd_pkg.sv ====
// Purpose: shared constants and types of the watchdog block
// Assumes: Avalon-MM register access, 32-bit data, byte addresses
// Notes: register byte address is four times its index
package wd_pkg;
  // ----------------------------------------------------------------
  // register indices and bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int IDX_W = 16;
  localparam logic [IDX_W-1:0] IDX_CTRL = 16'h0000;
  localparam logic [IDX_W-1:0] IDX_CAUSE = 16'h0001;
  localparam logic [IDX_W-1:0] IDX_EVT_STATUS = 16'h0002;
  localparam logic [IDX_W-1:0] IDX_EVT_MASK = 16'h0003;
  localparam logic [IDX_W-1:0] IDX_COUNT = 16'h0004;
  localparam logic [IDX_W-1:0] IDX_CLEAR = 16'hffff;
  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_DIS_BIT = 0;
  localparam int CAUSE_WD_BIT = 0;
  localparam int EVT_W = 4;
  localparam int EVT_CLEAR = 0;
  localparam int EVT_VECTOR = 1;
  localparam int EVT_POR = 2;
  localparam int EVT_INTRST = 3;
  localparam logic CTRL_DIS_RST = 1'b0;
  localparam logic [EVT_W-1:0] EVT_RST = 4'h0;
  localparam logic [EVT_W-1:0] MASK_RST = 4'h0;
  localparam int CNT_PRESC_LSB = 8;
  // ----------------------------------------------------------------
  // counter geometry and timing in crystal cycles
  // ----------------------------------------------------------------
  localparam int PRESC_W = 13;
  localparam int PRESC_KEEP = 4;
  localparam int TICK_BITS = 12;
  localparam int WD_W = 6;
  localparam int POR_CYCLES = 4096;
  localparam int POR_W = 13;
  localparam int PULSE_CYCLES = 32;
  localparam int PULSE_W = 6;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] be;
  } bus_req_t;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_OFF = 3'b010,
    ST_FIRE = 3'b100
  } wd_state_t;
endpackage : wd_pkg

// ==== hw/wd_prescaler.sv ====
// Purpose: shared free-running prescaler feeding the watchdog
// Assumes: clear inputs are single-cycle strobes
// Notes: low bits survive a partial clear
`timescale 1ns/1ps
`default_nettype none
module wd_prescaler #(
  parameter int W = wd_pkg::PRESC_W,
  parameter int KEEP = wd_pkg::PRESC_KEEP,
  parameter int TICK = wd_pkg::TICK_BITS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // controls
  input wire logic clr_all_i,
  input wire logic clr_upper_i,
  // outputs
  output logic [W-1:0] count_o,
  output logic tick_o
);
  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= '0;
    end else if (ce_i) begin
      if (clr_all_i) begin
        count_o <= '0;
      end else if (clr_upper_i) begin
        count_o <= {{(W-KEEP){1'b0}}, count_o[KEEP-1:0]};
      end else begin
        count_o <= count_o + 1'b1;
      end
    end
  end
  // one tick each time the low field wraps
  assign tick_o = ce_i && !clr_all_i && !clr_upper_i && (&count_o[TICK-1:0]);
endmodule : wd_prescaler
`default_nettype wire

// ==== hw/wd_reset_stretch.sv ====
// Purpose: stretches a fire strobe into a fixed low pulse on the pin
// Assumes: fire strobe may repeat; a running pulse is not restarted
// Notes: pin is open-drain style, value low while enabled
`timescale 1ns/1ps
`default_nettype none
module wd_reset_stretch #(
  parameter int LEN = wd_pkg::PULSE_CYCLES,
  parameter int CW = wd_pkg::PULSE_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // trigger
  input wire logic fire_i,
  // pin
  output logic pin_o,
  output logic pin_oe_o
);
  logic [CW-1:0] left;
  // ----------------------------------------------------------------
  // pulse counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left <= '0;
      pin_oe_o <= 1'b0;
      pin_o <= 1'b1;
    end else if (ce_i) begin
      if (fire_i && left == '0) begin
        left <= CW'(LEN - 1);
        pin_oe_o <= 1'b1;
        pin_o <= 1'b0;
      end else if (left != '0) begin
        left <= left - 1'b1;
      end else begin
        pin_oe_o <= 1'b0;
        pin_o <= 1'b1;
      end
    end
  end
endmodule : wd_reset_stretch
`default_nettype wire

// ==== hw/wd_top.sv ====
// Purpose: watchdog counter with clear location and reset pin drive
// Assumes: crystal clock is clk_i; Avalon-MM slave, one wait cycle
// Notes: timeout only resets, the interrupt covers side events only
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module wd_top #(
  parameter logic [7:0] RESET_VECTOR_LO = 8'h00, // arbitrary value
  parameter int WD_BITS = wd_pkg::WD_W
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // avalon-mm slave
  input wire logic [wd_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [wd_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [wd_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // system integration
  input wire logic internal_reset_i,
  input wire logic vector_fetch_i,
  input wire logic monitor_mode_i,
  input wire logic irq_high_test_voltage_i,
  input wire logic rst_high_test_voltage_i,
  // reset pin and status
  output logic reset_pin_o,
  output logic reset_pin_oe_o,
  output logic watchdog_cause_o,
  output logic watchdog_disable_o,
  output logic irq_o
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  wd_pkg::bus_req_t req;
  wd_pkg::wd_state_t state;
  wd_pkg::wd_state_t next_state;
  logic [wd_pkg::PRESC_W-1:0] presc;
  logic presc_tick;
  logic [WD_BITS-1:0] wd_count;
  logic [wd_pkg::EVT_W-1:0] evt_status;
  logic [wd_pkg::EVT_W-1:0] evt_mask;
  logic [wd_pkg::EVT_W-1:0] evt_set;
  logic [wd_pkg::POR_W-1:0] por_count;
  logic por_done;
  logic por_clear;
  logic acc_go;
  logic wr_go;
  logic wr_clear;
  logic wr_cause;
  logic wr_status;
  logic wr_mask;
  logic wr_ctrl;
  logic monitor_off;
  logic disabled;
  logic overflow;
  logic fire;
  logic presc_clr_all;
  logic [wd_pkg::DATA_W-1:0] next_rdata;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(
    input logic [wd_pkg::ADDR_W-1:0] a,
    input logic [wd_pkg::IDX_W-1:0] idx
  );
    hit = (a == {idx, 2'b00});
  endfunction : hit

  function automatic logic [wd_pkg::EVT_W-1:0] w1c(
    input logic [wd_pkg::EVT_W-1:0] cur,
    input logic [wd_pkg::EVT_W-1:0] set,
    input logic [wd_pkg::EVT_W-1:0] clr
  );
    // a new event wins over a clear in the same cycle
    w1c = (cur & ~clr) | set;
  endfunction : w1c

  // ----------------------------------------------------------------
  // bus request and handshake
  // ----------------------------------------------------------------
  always_comb begin
    req.read = avs_read_i;
    req.write = avs_write_i;
    req.addr = avs_address_i;
    req.wdata = avs_writedata_i;
    req.be = avs_byteenable_i;
  end

  // answer lands in the same cycle that waitrequest drops
  assign acc_go = ce_i && !avs_waitrequest_o && (req.read || req.write);
  assign wr_go = acc_go && req.write && (req.be != 4'h0);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (ce_i) begin
      if (!avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b1;
      end else if (req.read || req.write) begin
        avs_waitrequest_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  always_comb begin
    wr_clear = 1'b0;
    wr_cause = 1'b0;
    wr_status = 1'b0;
    wr_mask = 1'b0;
    wr_ctrl = 1'b0;
    if (!wr_go) begin
      wr_clear = 1'b0;
    end else if (hit(req.addr, wd_pkg::IDX_CLEAR)) begin
      wr_clear = 1'b1;
    end else if (hit(req.addr, wd_pkg::IDX_CTRL)) begin
      wr_ctrl = req.be[0];
    end else if (hit(req.addr, wd_pkg::IDX_CAUSE)) begin
      wr_cause = req.be[0];
    end else if (hit(req.addr, wd_pkg::IDX_EVT_STATUS)) begin
      wr_status = req.be[0];
    end else if (hit(req.addr, wd_pkg::IDX_EVT_MASK)) begin
      wr_mask = req.be[0];
    end
  end

  // ----------------------------------------------------------------
  // read data, unmapped reads give zero
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    if (hit(req.addr, wd_pkg::IDX_CLEAR)) begin
      // the location overlaps the vector, no counter state here
      next_rdata[7:0] = RESET_VECTOR_LO;
    end else if (hit(req.addr, wd_pkg::IDX_CTRL)) begin
      next_rdata[wd_pkg::CTRL_DIS_BIT] = watchdog_disable_o;
    end else if (hit(req.addr, wd_pkg::IDX_CAUSE)) begin
      next_rdata[wd_pkg::CAUSE_WD_BIT] = watchdog_cause_o;
    end else if (hit(req.addr, wd_pkg::IDX_EVT_STATUS)) begin
      next_rdata[wd_pkg::EVT_W-1:0] = evt_status;
    end else if (hit(req.addr, wd_pkg::IDX_EVT_MASK)) begin
      next_rdata[wd_pkg::EVT_W-1:0] = evt_mask;
    end else if (hit(req.addr, wd_pkg::IDX_COUNT)) begin
      next_rdata[WD_BITS-1:0] = wd_count;
      next_rdata[wd_pkg::CNT_PRESC_LSB +: wd_pkg::PRESC_W] = presc;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= '0;
    end else if (ce_i && avs_waitrequest_o && req.read) begin
      avs_readdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // configuration disable bit
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      watchdog_disable_o <= wd_pkg::CTRL_DIS_RST;
    end else if (ce_i && wr_ctrl) begin
      watchdog_disable_o <= req.wdata[wd_pkg::CTRL_DIS_BIT];
    end
  end

  // high test voltage on either pin stops the watchdog in monitor mode
  assign monitor_off = monitor_mode_i &&
    (irq_high_test_voltage_i || rst_high_test_voltage_i);
  assign disabled = watchdog_disable_o || monitor_off;

  // ----------------------------------------------------------------
  // power-up delay before the prescaler clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      por_count <= '0;
      por_done <= 1'b0;
    end else if (ce_i && !por_done) begin
      if (por_count == wd_pkg::POR_W'(wd_pkg::POR_CYCLES - 1)) begin
        por_done <= 1'b1;
      end else begin
        por_count <= por_count + 1'b1;
      end
    end
  end

  assign por_clear = !por_done &&
    (por_count == wd_pkg::POR_W'(wd_pkg::POR_CYCLES - 1));

  // ----------------------------------------------------------------
  // prescaler, shared with system integration
  // ----------------------------------------------------------------
  assign presc_clr_all = por_clear || internal_reset_i
    || vector_fetch_i;

  // runs straight off the crystal clock
  wd_prescaler #(
    .W(wd_pkg::PRESC_W),
    .KEEP(wd_pkg::PRESC_KEEP),
    .TICK(wd_pkg::TICK_BITS)
  ) u_presc (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .clr_all_i(presc_clr_all),
    .clr_upper_i(wr_clear),
    .count_o(presc),
    .tick_o(presc_tick)
  );

  // ----------------------------------------------------------------
  // watchdog state machine
  // ----------------------------------------------------------------
  // 64 ticks of 4096 cycles, minus the kept low prescaler bits
  assign overflow = (state == wd_pkg::ST_RUN) && presc_tick
    && (&wd_count);

  always_comb begin
    next_state = state;
    case (state)
      wd_pkg::ST_RUN: begin
        if (disabled) begin
          next_state = wd_pkg::ST_OFF;
        end else if (overflow && !wr_clear && !internal_reset_i) begin
          next_state = wd_pkg::ST_FIRE;
        end
      end
      wd_pkg::ST_OFF: begin
        if (!disabled) begin
          next_state = wd_pkg::ST_RUN;
        end
      end
      wd_pkg::ST_FIRE: begin
        next_state = wd_pkg::ST_RUN;
      end
      default: begin
        next_state = wd_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= wd_pkg::ST_RUN;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  assign fire = (state == wd_pkg::ST_FIRE);

  // ----------------------------------------------------------------
  // watchdog counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wd_count <= '0;
    end else if (ce_i) begin
      if (internal_reset_i || wr_clear || fire) begin
        wd_count <= '0;
      end else if (presc_tick && state == wd_pkg::ST_RUN && !disabled) begin
        wd_count <= wd_count + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // reset pin drive
  // ----------------------------------------------------------------
  wd_reset_stretch #(
    .LEN(wd_pkg::PULSE_CYCLES),
    .CW(wd_pkg::PULSE_W)
  ) u_stretch (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .fire_i(fire),
    .pin_o(reset_pin_o),
    .pin_oe_o(reset_pin_oe_o)
  );

  // ----------------------------------------------------------------
  // reset cause flag, write one to clear
  // ----------------------------------------------------------------
  // survives the system reset it caused, only rst_n_i or a written one clears it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      watchdog_cause_o <= 1'b0;
    end else if (ce_i) begin
      if (fire) begin
        watchdog_cause_o <= 1'b1;
      end else if (wr_cause && req.wdata[wd_pkg::CAUSE_WD_BIT]) begin
        watchdog_cause_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // side events and interrupt
  // ----------------------------------------------------------------
  // timeout is deliberately absent: it resets, never interrupts
  always_comb begin
    evt_set = '0;
    evt_set[wd_pkg::EVT_CLEAR] = wr_clear;
    evt_set[wd_pkg::EVT_VECTOR] = vector_fetch_i;
    evt_set[wd_pkg::EVT_POR] = por_clear;
    evt_set[wd_pkg::EVT_INTRST] = internal_reset_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      evt_status <= wd_pkg::EVT_RST;
    end else if (ce_i) begin
      evt_status <= w1c(evt_status, evt_set,
        wr_status ? req.wdata[wd_pkg::EVT_W-1:0] : '0);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      evt_mask <= wd_pkg::MASK_RST;
    end else if (ce_i && wr_mask) begin
      evt_mask <= req.wdata[wd_pkg::EVT_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(evt_status & evt_mask);
    end
  end
endmodule : wd_top
`default_nettype wire

// ==== testbench/wd_top_sva.sv ====
// Purpose: port assertions for the watchdog top
// Assumes: one clock domain, ce_i high in normal runs
// Notes: stretch length counted in helper logic
`timescale 1ns/1ps
`default_nettype none
module wd_top_sva #(
  parameter logic [7:0] RESET_VECTOR_LO = 8'h00
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // bus
  input wire logic [wd_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [wd_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [wd_pkg::DATA_W-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // system side
  input wire logic internal_reset_i,
  input wire logic monitor_mode_i,
  input wire logic irq_high_test_voltage_i,
  input wire logic rst_high_test_voltage_i,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe_o,
  input wire logic watchdog_cause_o,
  input wire logic watchdog_disable_o,
  input wire logic irq_o
);
  // ----
  // helpers
  // ----
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic [6:0] low_len;
  logic done;
  logic ctrl_wr;
  logic cause_clr;
  logic off_mon;
  assign done = !avs_waitrequest_o && ce_i;
  assign ctrl_wr = done && avs_write_i && avs_byteenable_i[0]
    && avs_address_i == 18'h00000;
  assign cause_clr = done && avs_write_i && avs_byteenable_i[0]
    && avs_writedata_i[0] && avs_address_i == 18'h00004;
  assign off_mon = monitor_mode_i
    && (irq_high_test_voltage_i || rst_high_test_voltage_i);
  // frozen edges are not counted, so ce_i gaps do not stretch it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_len <= 7'h00;
    end else if (ce_i) begin
      low_len <= reset_pin_oe_o ? low_len + 7'h01 : 7'h00;
    end
  end
  sequence s_taken;
    (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i;
  endsequence
  sequence s_held(x);
    x [*3];
  endsequence
  // ----
  // assertions
  // ----
  a_bus_answer: assert property (s_taken |=> !avs_waitrequest_o)
    else $error("bus request not answered in one cycle");
  a_wait_one: assert property (done |=> avs_waitrequest_o)
    else $error("wait request low for more than one cycle");
  a_clear_read: assert property (done && avs_read_i
    && avs_address_i == {wd_pkg::IDX_CLEAR, 2'b00}
    |-> avs_readdata_o == {24'h000000, RESET_VECTOR_LO})
    else $error("clear location read is not the vector byte");
  a_pin_driven: assert property (reset_pin_oe_o |-> !reset_pin_o)
    else $error("reset pin enabled but not low");
  a_pulse_len: assert property ($fell(reset_pin_oe_o) |-> low_len == 7'd32)
    else $error("reset pulse length differs from 32");
  a_cause_set: assert property ($rose(reset_pin_oe_o)
    |-> watchdog_cause_o && !$rose(irq_o))
    else $error("timeout without cause flag or with interrupt");
  a_cause_sticky: assert property (watchdog_cause_o && !cause_clr
    && !$past(cause_clr) |=> watchdog_cause_o)
    else $error("cause flag dropped without a clear");
  a_disable_follow: assert property (ctrl_wr
    |=> watchdog_disable_o == $past(avs_writedata_i[0]))
    else $error("disable output does not follow control bit");
  a_off_quiet: assert property (s_held(watchdog_disable_o)
    |-> !$rose(reset_pin_oe_o))
    else $error("reset fired while disabled");
  a_monitor_quiet: assert property (s_held(off_mon)
    |-> !$rose(reset_pin_oe_o))
    else $error("reset fired in monitor mode with high voltage");
  a_intrst_quiet: assert property (s_held(internal_reset_i)
    |-> !$rose(reset_pin_oe_o))
    else $error("reset fired during internal reset");
endmodule : wd_top_sva
bind wd_top wd_top_sva #(.RESET_VECTOR_LO(RESET_VECTOR_LO)) i_wd_top_sva (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .internal_reset_i(internal_reset_i), .monitor_mode_i(monitor_mode_i),
  .irq_high_test_voltage_i(irq_high_test_voltage_i),
  .rst_high_test_voltage_i(rst_high_test_voltage_i),
  .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o),
  .watchdog_cause_o(watchdog_cause_o), .irq_o(irq_o),
  .watchdog_disable_o(watchdog_disable_o)
);
`default_nettype wire

// ==== testbench/sys_reset_model.sv ====
// Purpose: system reset logic seen from the reset pin
// Assumes: reset line carries a pull-up
// Notes: fetches the reset vector a few cycles after release
`timescale 1ns/1ps
`default_nettype none
module sys_reset_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // reset pin
  input wire logic pin_i,
  input wire logic pin_oe_i,
  // toward block and bench
  output logic vector_fetch_o,
  output var int pulse_cnt_o,
  output var int last_len_o
);
  // ----
  // line watch
  // ----
  logic line;
  int run;
  int gap;
  // undriven line floats up, never keeps the last driven level
  assign line = pin_oe_i ? pin_i : 1'b1;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run <= 0;
      gap <= 0;
      pulse_cnt_o <= 0;
      last_len_o <= 0;
      vector_fetch_o <= 1'b0;
    end else begin
      vector_fetch_o <= (gap == 1);
      if (gap != 0) begin
        gap <= gap - 1;
      end
      if (line == 1'b0) begin
        run <= run + 1;
      end else if (run != 0) begin
        last_len_o <= run;
        pulse_cnt_o <= pulse_cnt_o + 1;
        run <= 0;
        gap <= 4;
      end
    end
  end
endmodule : sys_reset_model
`default_nettype wire

// ==== testbench/tb_watchdog_reset_counter.sv ====
// Purpose: self-checking bench for the watchdog block
// Assumes: ce_i held high; watchdog counter shortened to WDB bits
// Notes: register model kept in plain ints
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_reset_counter;
  // ----
  // signals
  // ----
  localparam int WDB = 2;
  localparam int TOUT = (1 << (12 + WDB)) - 16;
  localparam logic [7:0] VEC_LO = 8'h5a; // arbitrary value
  logic [15:0] regs [6] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'hffff, 16'h10};
  logic clk = 1'b0;
  logic rst_n, ce, int_rst, vfetch, mon, irq_hv, rst_hv;
  logic pin, pin_oe, cause, dis, irq, wait_req;
  logic [31:0] rdata, q;
  wd_pkg::bus_req_t req;
  int pulse_cnt, last_len, n;
  int m_ctrl, m_cause, m_stat, m_mask;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 15;
  always #4 clk = ~clk;
  wd_top #(.RESET_VECTOR_LO(VEC_LO), .WD_BITS(WDB)) i_wd_top (
    .clk_i(clk), .rst_n_i(rst_n), .ce_i(ce),
    .avs_address_i(req.addr), .avs_read_i(req.read),
    .avs_write_i(req.write), .avs_writedata_i(req.wdata),
    .avs_byteenable_i(req.be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_req), .internal_reset_i(int_rst),
    .vector_fetch_i(vfetch), .monitor_mode_i(mon),
    .irq_high_test_voltage_i(irq_hv), .rst_high_test_voltage_i(rst_hv),
    .reset_pin_o(pin), .reset_pin_oe_o(pin_oe), .irq_o(irq),
    .watchdog_cause_o(cause), .watchdog_disable_o(dis));
  sys_reset_model i_sys_reset_model (
    .clk_i(clk), .rst_n_i(rst_n), .pin_i(pin), .pin_oe_i(pin_oe),
    .vector_fetch_o(vfetch), .pulse_cnt_o(pulse_cnt),
    .last_len_o(last_len));
  // ----
  // tasks
  // ----
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [15:0] idx,
                     input logic [31:0] d, output logic [31:0] v);
    @(posedge clk);
    req.read <= !w;
    req.write <= w;
    req.addr <= {idx, 2'b00};
    req.wdata <= d;
    // waitrequest and read data taken at the same rising edge
    do begin
      @(posedge clk);
    end while (wait_req !== 1'b0);
    v = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask : bus
  function automatic logic [31:0] model(input logic [15:0] idx);
    case (idx)
      16'h0000: return 32'(m_ctrl);
      16'h0001: return 32'(m_cause);
      16'h0002: return 32'(m_stat);
      16'h0003: return 32'(m_mask);
      16'hffff: return {24'h000000, VEC_LO};
      default: return 32'h0;
    endcase
  endfunction : model
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, idx, d, v);
    case (idx)
      16'h0000: m_ctrl = int'(d[0]);
      16'h0001: m_cause = d[0] ? 0 : m_cause;
      16'h0002: m_stat = m_stat & ~int'(d[3:0]);
      16'h0003: m_mask = int'(d[3:0]);
      16'hffff: m_stat = m_stat | 1;
      default: ;
    endcase
  endtask : wr
  task automatic rdc(input logic [15:0] idx);
    logic [31:0] v;
    bus(1'b0, idx, 32'h0, v);
    chk($sformatf("reg %h", idx), v, model(idx));
  endtask : rdc
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      wrap_up();
    end
  end
  // ----
  // sequence
  // ----
  initial begin
    req = '0;
    req.be = 4'hf;
    {rst_n, int_rst, mon, irq_hv, rst_hv} = 5'h00;
    ce = 1'b1;
    {m_ctrl, m_cause, m_stat, m_mask} = {32'h0, 32'h0, 32'h0, 32'h0};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("reset out", {wait_req, pin, pin_oe, cause, irq}, 5'h18);
    repeat (4200) @(posedge clk);
    m_stat = 4;
    bus(1'b0, wd_pkg::IDX_COUNT, 32'h0, q);
    chk("por prescaler", 32'(q[20:8] < 13'd200), 1);
    foreach (regs[i]) rdc(regs[i]);
    wr(16'h0010, $random(seed));
    rdc(16'h0010);
    $display("test registers done");
    for (int k = 0; k < 2; k++) begin
      wr(wd_pkg::IDX_EVT_MASK, k == 0 ? 32'h8 : 32'h0);
      @(posedge clk);
      int_rst <= 1'b1;
      repeat (3) @(posedge clk);
      int_rst <= 1'b0;
      m_stat = m_stat | 8;
      repeat (3) @(negedge clk);
      chk("irq", irq, k == 0);
      bus(1'b0, wd_pkg::IDX_COUNT, 32'h0, q);
      chk("count", {q[20:12], q[5:0]}, 0);
      rdc(wd_pkg::IDX_EVT_STATUS);
      wr(wd_pkg::IDX_EVT_STATUS, 32'hf);
      repeat (2) @(negedge clk);
      chk("irq", irq, 0);
    end
    $display("test interrupt done");
    wr(wd_pkg::IDX_CLEAR, $random(seed));
    bus(1'b0, wd_pkg::IDX_COUNT, 32'h0, q);
    chk("count", {q[20:13], q[5:0]}, 0);
    n = 0;
    while (pin_oe !== 1'b1 && n < TOUT + 200) begin
      @(posedge clk);
      n++;
    end
    chk("fire time", 32'(n >= TOUT - 16 && n <= TOUT + 24), 1);
    repeat (48) @(negedge clk);
    m_cause = 1;
    m_stat = m_stat | 2;
    chk("pulse len", last_len, wd_pkg::PULSE_CYCLES);
    chk("pulse count", pulse_cnt, 1);
    chk("cause", {cause, irq}, 2'b10);
    rdc(wd_pkg::IDX_CAUSE);
    rdc(wd_pkg::IDX_EVT_STATUS);
    wr(wd_pkg::IDX_CAUSE, 32'h1);
    repeat (2) @(negedge clk);
    chk("cause", cause, 0);
    $display("test timeout done");
    for (int k = 0; k < 3; k++) begin
      wr(wd_pkg::IDX_CTRL, k == 0);
      mon <= k != 0;
      irq_hv <= k == 1;
      rst_hv <= k == 2;
      wr(wd_pkg::IDX_CLEAR, $random(seed));
      chk("disable", dis, k == 0);
      repeat (TOUT + 64) @(posedge clk);
      bus(1'b0, wd_pkg::IDX_COUNT, 32'h0, q);
      chk("held count", q[5:0], 0);
      chk("held pulses", pulse_cnt, 1);
      rdc(wd_pkg::IDX_CTRL);
      wr(wd_pkg::IDX_CTRL, 32'h0);
      {mon, irq_hv, rst_hv} <= 3'h0;
    end
    $display("test disable done");
    wrap_up();
  end
endmodule : tb_watchdog_reset_counter
`default_nettype wire
